//--- bench/slice_array_model.sv
// Behavioural model of the cascaded slice array and its end pins
`timescale 1ns/100ps
module slice_array_model #(
  parameter int W = 8
) (
  // Clock
  input wire logic clk,
  // Instruction lines
  input wire logic [2:0] dest,
  input wire logic [2:0] func,
  input wire logic [2:0] src,
  input wire logic cin,
  input wire logic [3:0] aA,
  input wire logic [3:0] bA,
  // Status of the top slice
  output logic sign,
  output logic overflow_flag,
  // End pins: file low, file high, Q low, Q high
  input wire logic [3:0] hostOut,
  input wire logic [3:0] hostOe,
  output logic [3:0] pin,
  output logic clash
);
  logic [W-1:0] file [16];
  logic [W-1:0] q, r, s, f;
  logic [3:0] devOe, devOut;
  logic [3:0] last = 4'h0;
  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    r = (src == 3'h1 || src == 3'h4) ? file[aA] : '0;
    s = src == 3'h2 ? q : (src == 3'h4 ? '0 : file[bA]);
    // Subtract is S minus R: inverted R, carry supplies the one
    if (func == 3'h1) r = ~r;
    f = func == 3'h3 ? r | s : (func == 3'h4 ? r & s : r + s + cin);
    overflow_flag = func < 3'h3 && r[W-1] == s[W-1] && f[W-1] != r[W-1];
    sign = f[W-1];
  end
  //////////////////////////////////////////////////////////////////////////
  // Array drives its low ends on a down shift, its high ends on an up shift
  assign devOe = {dest[2:1] == 2'b11, dest[2:1] == 2'b10,
                  dest[2:1] == 2'b11, dest[2:1] == 2'b10};
  assign devOut = {q[W-1], q[0], f[W-1], f[0]};
  assign clash = |(devOe & hostOe);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // A floating line shows the inverse of its last level
      pin[i] = hostOe[i] ? hostOut[i] : (devOe[i] ? devOut[i] : ~last[i]);
    end
  end
  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    last <= pin;
    case (dest)
      3'h0: q <= f;
      3'h2, 3'h3: file[bA] <= f;
      3'h4, 3'h5: begin
        file[bA] <= {pin[1], f[W-1:1]};
        q <= {pin[3], q[W-1:1]};
      end
      3'h6, 3'h7: begin
        file[bA] <= {f[W-2:0], pin[0]};
        q <= {q[W-2:0], pin[2]};
      end
      default: ;
    endcase
  end
endmodule

//--- bench/slice_host_ctrl_test.sv
// Self-checking bench for the slice array host controller
`timescale 1ns/100ps
module slice_host_ctrl_test import slice_ctrl_pkg::*;;
  localparam int W = 8;
  logic ref_clk = 1'b0;
  logic rst_n;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, carryInput, aluSignOut, overflowFlag, clash;
  logic [2:0] destinationField, functionField, sourceField;
  logic [3:0] aAddress, bAddress, hostOut, hostOe, pin;
  int fails = 0;
  int num_checks = 0;
  int addSteps = 0;
  int subSteps = 0;
  int badSteps = 0;
  always #5 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////////////
  slice_host_ctrl #(.MUL_WIDTH(W)) slice_host_ctrl_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .destinationField(destinationField),
    .functionField(functionField), .sourceField(sourceField),
    .carryInput(carryInput), .aAddress(aAddress), .bAddress(bAddress),
    .aluSignOut(aluSignOut), .overflowFlag(overflowFlag),
    .fileShiftLowIn(pin[0]), .fileShiftLowOut(hostOut[0]),
    .fileShiftLowOe(hostOe[0]), .fileShiftHighIn(pin[1]),
    .fileShiftHighOut(hostOut[1]), .fileShiftHighOe(hostOe[1]),
    .qLowShiftIn(pin[2]), .qLowShiftOut(hostOut[2]),
    .qLowShiftOe(hostOe[2]), .qHighShiftIn(pin[3]),
    .qHighShiftOut(hostOut[3]), .qHighShiftOe(hostOe[3])
  );
  slice_array_model #(.W(W)) slice_array_model_inst (
    .clk(ref_clk), .dest(destinationField), .func(functionField),
    .src(sourceField), .cin(carryInput), .aA(aAddress), .bA(bAddress),
    .sign(aluSignOut), .overflow_flag(overflowFlag), .hostOut(hostOut),
    .hostOe(hostOe), .pin(pin), .clash(clash)
  );
  //////////////////////////////////////////////////////////////////////////
  // Step watcher: only multiply steps use a down shift with a sum
  always @(posedge ref_clk) begin
    if (clash === 1'b1) badSteps++;
    if (destinationField === DEST_SHIFT_DOWN &&
        functionField !== FUNC_OR) begin
      if (functionField === FUNC_ADD && carryInput === 1'b0) addSteps++;
      if (functionField === FUNC_SUB && carryInput === 1'b1) subSteps++;
      if (sourceField !== (pin[2] ? SRC_AB : SRC_ZB)) badSteps++;
      if (aAddress !== 4'h4 || bAddress !== 4'h5) badSteps++;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Ready and read data are taken at the rising edge that samples them
  task automatic wait_ready(output logic [31:0] d);
    logic ok;
    int n = 0;
    do begin
      @(posedge ref_clk);
      ok = hreadyout;
      d = hrdata;
      n++;
    end while (ok !== 1'b1 && n < 50);
    check(ok, 1'b1, "bus wait");
    if (ok !== 1'b1) wrap_up();
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready(d);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready(d);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check(hreadyout, 1'b1, "ready");
    check(destinationField, DEST_NONE, "idle dest");
    check(hostOe, 4'h0, "idle ends");
    bus(1'b0, CTRL_OFFSET, 32'h0, rd);
    check(rd, 32'h0, "ctrl reset");
    bus(1'b0, OPER_OFFSET, 32'h0, rd);
    check(rd, 32'(OPER_RESET), "oper reset");
    bus(1'b0, STATUS_OFFSET, 32'h0, rd);
    check(rd[7:0], 8'h04, "status idle");
    bus(1'b0, 8'h10, 32'h0, rd);
    check(rd, 32'h0, "unmapped");
    check(hresp, 1'b0, "okay");
  endtask

  task automatic test_shift(input logic [1:0] m, input logic up);
    logic [7:0] b, q;
    logic [1:0] fill;
    logic [15:0] got;
    b = 8'h4b;
    q = 8'h96;
    case (m)
      MODE_ZERO: fill = 2'b00;
      MODE_ONE: fill = 2'b11;
      MODE_ROTATE: fill = up ? {b[7], q[7]} : {b[0], q[0]};
      default: fill = up ? {q[7], 1'b0} : {b[7], b[0]};
    endcase
    slice_array_model_inst.file[8] = b;
    slice_array_model_inst.q = q;
    bus(1'b1, CTRL_OFFSET, {29'h0, m, 1'b0}, rd);
    bus(1'b1, ISSUE_OFFSET, {14'h0, 4'h8, 4'h0, 1'b0, SRC_ZB, FUNC_OR,
        up ? 3'h6 : DEST_SHIFT_DOWN}, rd);
    repeat (3) @(posedge ref_clk);
    b = up ? {b[6:0], fill[1]} : {fill[1], b[7:1]};
    q = up ? {q[6:0], fill[0]} : {fill[0], q[7:1]};
    got = {slice_array_model_inst.file[8], slice_array_model_inst.q};
    check(got[15:8], b, "file");
    check(got[7:0], q, "q");
  endtask

  task automatic test_mul(input logic [7:0] mc, input logic [7:0] ml);
    logic [15:0] p, got;
    int n = 0;
    p = {{8{mc[7]}}, mc} * {{8{ml[7]}}, ml};
    slice_array_model_inst.file[4] = mc;
    slice_array_model_inst.file[5] = 8'h5a;
    slice_array_model_inst.file[6] = ml;
    addSteps = 0;
    subSteps = 0;
    // Mode one is set too: the multiply must ignore it
    bus(1'b1, CTRL_OFFSET, 32'h3, rd);
    do begin
      bus(1'b0, STATUS_OFFSET, 32'h0, rd);
      n++;
    end while (rd[1] !== 1'b1 && n < 40);
    check(rd[7:0], 8'h06, "done idle");
    if (rd[1] !== 1'b1) wrap_up();
    got = {slice_array_model_inst.file[5], slice_array_model_inst.file[7]};
    check(got, p, "product");
    check(slice_array_model_inst.file[4], mc, "mcand");
    check(addSteps, W - 1, "adds");
    check(subSteps, 1, "subs");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    test_reset();
    bus(1'b1, OPER_OFFSET, 32'h7654, rd);
    bus(1'b0, OPER_OFFSET, 32'h0, rd);
    check(rd, 32'h7654, "oper");
    for (int i = 0; i < 8; i++) begin
      test_shift(2'(i / 2), i[0]);
    end
    test_mul(8'h03, 8'h05);
    test_mul(8'hf9, 8'h06);
    test_mul(8'h05, 8'hfd);
    test_mul(8'h80, 8'h80);
    test_mul(8'h7f, 8'h80);
    test_mul(8'h00, 8'hff);
    check(badSteps, 0, "steps");
    wrap_up();
  end
endmodule

//--- logic/mul_sequencer.sv
// Add-and-shift multiply sequence and single-instruction issue
`timescale 1ns/100ps
module mul_sequencer import slice_ctrl_pkg::*; #(
  parameter int WIDTH = MUL_WIDTH_DEFAULT
) (
  // Clock and reset
  input wire logic refClk,
  input wire logic rstSyncN,
  // Orders
  input wire logic start,
  input wire logic issue,
  input wire logic [ISSUE_WIDTH-1:0] issueWord,
  input wire logic [15:0] operands,
  // Progress
  output mul_state_type state,
  output logic [5:0] count,
  output logic stepActive,
  output logic done,
  // Instruction fields
  output logic [2:0] dest,
  output logic [2:0] func,
  output logic [2:0] src,
  output logic carry,
  output logic [3:0] aAddr,
  output logic [3:0] bAddr
);

  mul_state_type next_state;
  logic [5:0] next_count;
  logic next_stepActive, next_done, next_carry;
  logic [2:0] next_dest, next_func, next_src;
  logic [3:0] next_aAddr, next_bAddr;
  logic [3:0] mcand, pp, mult, low;

  assign mcand = operands[OPER_MCAND_LSB +: 4];
  assign pp = operands[OPER_PP_LSB +: 4];
  assign mult = operands[OPER_MULT_LSB +: 4];
  assign low = operands[OPER_LOW_LSB +: 4];

  always_comb begin
    next_state = state;
    next_count = count;
    // Each state after idle lasts one cycle except the add loop
    unique case (state)
      ST_IDLE: if (start) next_state = ST_LOADQ;
      ST_LOADQ: next_state = ST_CLEAR;
      ST_CLEAR: begin
        next_state = ST_ADD;
        next_count = 6'(WIDTH - 2);
      end
      ST_ADD: begin
        if (count == 6'h00) next_state = ST_SUB;
        else next_count = count - 6'h01;
      end
      ST_SUB: next_state = ST_STORE;
      ST_STORE: next_state = ST_IDLE;
    endcase
    next_dest = DEST_NONE;
    next_func = FUNC_ADD;
    next_src = SRC_ZQ;
    next_carry = 1'b0;
    next_aAddr = 4'h0;
    next_bAddr = 4'h0;
    unique case (next_state)
      ST_IDLE: if (issue && !start && state == ST_IDLE) begin
        next_dest = issueWord[ISSUE_DEST_LSB +: 3];
        next_func = issueWord[ISSUE_FUNC_LSB +: 3];
        next_src = issueWord[ISSUE_SRC_LSB +: 3];
        next_carry = issueWord[ISSUE_CARRY_BIT];
        next_aAddr = issueWord[ISSUE_A_LSB +: 4];
        next_bAddr = issueWord[ISSUE_B_LSB +: 4];
      end
      ST_LOADQ: begin
        next_aAddr = mult;
        next_dest = DEST_QREG;
        next_func = FUNC_OR;
        next_src = SRC_ZA;
      end
      ST_CLEAR: begin
        next_bAddr = pp;
        next_dest = DEST_MOVE;
        next_func = FUNC_AND;
        next_src = SRC_ZB;
      end
      ST_ADD, ST_SUB: begin
        next_aAddr = mcand;
        next_bAddr = pp;
        next_dest = DEST_SHIFT_DOWN;
        next_src = SRC_AB;
        next_func = (next_state == ST_SUB) ? FUNC_SUB : FUNC_ADD;
        next_carry = (next_state == ST_SUB);
      end
      ST_STORE: begin
        next_bAddr = low;
        next_dest = DEST_MOVE;
        next_func = FUNC_OR;
        next_src = SRC_ZQ;
      end
    endcase
    next_stepActive = (next_state == ST_ADD) || (next_state == ST_SUB);
    next_done = (state == ST_STORE);
  end

  always_ff @(posedge refClk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state <= ST_IDLE;
      count <= 6'h00;
      stepActive <= 1'b0;
      done <= 1'b0;
      dest <= DEST_NONE;
      func <= FUNC_ADD;
      src <= SRC_ZQ;
      carry <= 1'b0;
      aAddr <= 4'h0;
      bAddr <= 4'h0;
    end else begin
      state <= next_state;
      count <= next_count;
      stepActive <= next_stepActive;
      done <= next_done;
      dest <= next_dest;
      func <= next_func;
      src <= next_src;
      carry <= next_carry;
      aAddr <= next_aAddr;
      bAddr <= next_bAddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge refClk); endclocking
  default disable iff (!rstSyncN);

  step_fields_a: assert property (stepActive |->
    dest == DEST_SHIFT_DOWN && src[0] && !src[2] && aAddr == mcand &&
    bAddr == pp)
    else $error("multiply step fields wrong");
  add_carry_a: assert property (state == ST_ADD |->
    func == FUNC_ADD && !carry)
    else $error("add step must add with carry low");
  loop_exit_a: assert property (state == ST_ADD && count == 6'h00 |=>
    state == ST_SUB && func == FUNC_SUB && carry ##1 state == ST_STORE)
    else $error("final subtract step missing");
  loop_start_a: assert property ($rose(state == ST_ADD) |->
    count == 6'(WIDTH - 2))
    else $error("add loop length wrong");
  load_clear_a: assert property (state == ST_LOADQ |->
    aAddr == mult && dest == DEST_QREG ##1 state == ST_CLEAR &&
    bAddr == pp)
    else $error("multiplier load or clear wrong");
  store_low_a: assert property (state == ST_SUB |=>
    state == ST_STORE && bAddr == low && src == SRC_ZQ ##1 done)
    else $error("low half not stored");

  mul_run_c: cover property (start && state == ST_IDLE ##[1:80] done);
  issue_c: cover property (issue && state == ST_IDLE && !start);

endmodule

//--- logic/shift_end_mux.sv
// End-of-array shift input selection for the slice cascade
`timescale 1ns/100ps
module shift_end_mux import slice_ctrl_pkg::*; (
  // Control
  input wire logic [1:0] mode,
  input wire logic shifting,
  input wire logic up,
  input wire logic signIn,
  // Levels read from the array ends
  input wire logic fileLowIn,
  input wire logic fileHighIn,
  input wire logic qLowIn,
  input wire logic qHighIn,
  // Drive values and enables
  output logic fileLowOut,
  output logic fileHighOut,
  output logic qLowOut,
  output logic qHighOut,
  output logic lowOe,
  output logic highOe
);

  always_comb begin
    // At most one end is driven; during a shift the other end is the array's output
    lowOe = shifting && up;
    highOe = shifting && !up;
    fileLowOut = 1'b0;
    fileHighOut = 1'b0;
    qLowOut = 1'b0;
    qHighOut = 1'b0;
    unique case (shift_mode_type'(mode))
      MODE_ZERO: begin
        fileLowOut = 1'b0;
        qLowOut = 1'b0;
        fileHighOut = 1'b0;
        qHighOut = 1'b0;
      end
      MODE_ONE: begin
        fileLowOut = 1'b1;
        qLowOut = 1'b1;
        fileHighOut = 1'b1;
        qHighOut = 1'b1;
      end
      MODE_ROTATE: begin
        fileLowOut = fileHighIn;
        fileHighOut = fileLowIn;
        qLowOut = qHighIn;
        qHighOut = qLowIn;
      end
      MODE_ARITH: begin
        qLowOut = 1'b0;
        fileLowOut = qHighIn;
        qHighOut = fileLowIn;
        fileHighOut = signIn;
      end
    endcase
  end

endmodule

//--- logic/slice_ctrl_pkg.sv
// Constants shared by the slice-array host controller
package slice_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] OPER_OFFSET = 8'h08;
  localparam logic [7:0] ISSUE_OFFSET = 8'h0c;

  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam logic [1:0] CTRL_MODE_RESET = 2'h0;

  // Operand register fields: four 4-bit register-file addresses
  localparam int OPER_MCAND_LSB = 0;
  localparam int OPER_PP_LSB = 4;
  localparam int OPER_MULT_LSB = 8;
  localparam int OPER_LOW_LSB = 12;
  localparam logic [15:0] OPER_RESET = 16'h3210;

  // Single-instruction issue register fields
  localparam int ISSUE_DEST_LSB = 0;
  localparam int ISSUE_FUNC_LSB = 3;
  localparam int ISSUE_SRC_LSB = 6;
  localparam int ISSUE_CARRY_BIT = 9;
  localparam int ISSUE_A_LSB = 10;
  localparam int ISSUE_B_LSB = 14;
  localparam int ISSUE_WIDTH = 18;

  // Status register fields
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DONE_BIT = 1;
  localparam int STATUS_STATE_LSB = 2;
  localparam int STATUS_COUNT_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction field codes
  localparam logic [2:0] DEST_QREG = 3'h0;
  localparam logic [2:0] DEST_NONE = 3'h1;
  localparam logic [2:0] DEST_MOVE = 3'h2;
  localparam logic [2:0] DEST_SHIFT_DOWN = 3'h4;
  localparam logic [2:0] FUNC_ADD = 3'h0;
  localparam logic [2:0] FUNC_SUB = 3'h1;
  localparam logic [2:0] FUNC_OR = 3'h3;
  localparam logic [2:0] FUNC_AND = 3'h4;
  localparam logic [2:0] SRC_AB = 3'h1;
  localparam logic [2:0] SRC_ZQ = 3'h2;
  localparam logic [2:0] SRC_ZB = 3'h3;
  localparam logic [2:0] SRC_ZA = 3'h4;

  localparam int MUL_WIDTH_DEFAULT = 8;

  typedef enum logic [1:0] {
    MODE_ZERO = 2'h0,
    MODE_ONE = 2'h1,
    MODE_ROTATE = 2'h2,
    MODE_ARITH = 2'h3
  } shift_mode_type;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LOADQ = 6'h02,
    ST_CLEAR = 6'h04,
    ST_ADD = 6'h08,
    ST_SUB = 6'h10,
    ST_STORE = 6'h20
  } mul_state_type;

endpackage

//--- logic/slice_host_ctrl.sv
// Host controller for a cascaded 4-bit ALU slice array
//
// Operation
// - Shift direction bit picks which array end gets driven, never both.
// - Zero mode, down shift: low into file MSB and Q MSB.
// - Zero mode, up shift: low into file LSB and Q LSB.
// - One mode equals zero mode but fills with high.
// - Rotate mode wraps file end bits around in the shift direction.
// - Rotate mode wraps Q end bits the same way.
// - Arithmetic up shift: zero into Q LSB, Q MSB into file LSB.
// - Arithmetic down shift: file LSB into Q MSB, sign into file MSB.
// - Multiply takes one clock per multiplier bit.
// - Multiplicand is added only when current multiplier LSB is one.
// - Steps use shift-down destination, add or subtract function, source 1 or 3.
// - Operand-source bit is the inverse of the Q low shift pin.
// - File low shift pin feeds the Q MSB shift input.
// - File MSB shift input gets sign XOR overflow during multiply.
// - Last step, on the multiplier sign, subtracts instead of adds.
// - Load multiplier into Q, clear product; afterwards store low half.
// - A port selects multiplicand; B port the partial product.
`timescale 1ns/100ps
module slice_host_ctrl import slice_ctrl_pkg::*; #(
  parameter int MUL_WIDTH = MUL_WIDTH_DEFAULT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Instruction lines to the array
  output logic [2:0] destinationField,
  output logic [2:0] functionField,
  output logic [2:0] sourceField,
  output logic carryInput,
  output logic [3:0] aAddress,
  output logic [3:0] bAddress,
  // Status from the array's most significant slice
  input wire logic aluSignOut,
  input wire logic overflowFlag,
  // File shifter end pins
  input wire logic fileShiftLowIn,
  output logic fileShiftLowOut,
  output logic fileShiftLowOe,
  input wire logic fileShiftHighIn,
  output logic fileShiftHighOut,
  output logic fileShiftHighOe,
  // Q register end pins
  input wire logic qLowShiftIn,
  output logic qLowShiftOut,
  output logic qLowShiftOe,
  input wire logic qHighShiftIn,
  output logic qHighShiftOut,
  output logic qHighShiftOe
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  // Release is synchronous so no flop sees reset end near a clock edge
  logic rstMeta, rstSyncN;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and registers
  logic wrPending, next_wrPending;
  logic [7:0] wrAddr, next_wrAddr;
  logic [1:0] modeReg, next_modeReg;
  logic [15:0] operReg, next_operReg;
  logic [ISSUE_WIDTH-1:0] issueReg, next_issueReg;
  logic startPulse, next_startPulse;
  logic issuePulse, next_issuePulse;
  logic doneFlag, next_doneFlag;
  logic [31:0] next_hrdata;
  logic addrPhase;
  logic [31:0] statusWord;

  mul_state_type seqState;
  logic [5:0] seqCount;
  logic seqStep, seqDone;
  logic [2:0] seqDest, seqFunc, seqSrc;
  logic seqCarry;
  logic [3:0] seqA, seqB;

  // Zero wait states: ready is constant, writes land in the data phase
  assign addrPhase = hsel && hready && htrans[1];

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[STATUS_BUSY_BIT] = (seqState != ST_IDLE);
    statusWord[STATUS_DONE_BIT] = doneFlag;
    statusWord[STATUS_STATE_LSB +: 6] = seqState;
    statusWord[STATUS_COUNT_LSB +: 6] = seqCount;
  end

  always_comb begin
    next_wrPending = addrPhase && hwrite;
    next_wrAddr = addrPhase ? haddr[7:0] : wrAddr;
    next_modeReg = modeReg;
    next_operReg = operReg;
    next_issueReg = issueReg;
    next_startPulse = 1'b0;
    next_issuePulse = 1'b0;
    next_doneFlag = doneFlag;
    if (wrPending) begin
      unique case (wrAddr)
        CTRL_OFFSET: begin
          next_modeReg = hwdata[CTRL_MODE_LSB +: 2];
          next_startPulse = hwdata[CTRL_START_BIT];
          if (hwdata[CTRL_START_BIT]) next_doneFlag = 1'b0;
        end
        OPER_OFFSET: next_operReg = hwdata[15:0];
        ISSUE_OFFSET: begin
          next_issueReg = hwdata[ISSUE_WIDTH-1:0];
          next_issuePulse = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // A finishing multiply wins over a clearing write
    if (seqDone) next_doneFlag = 1'b1;
    next_hrdata = hrdata;
    if (addrPhase && !hwrite) begin
      unique case (haddr[7:0])
        CTRL_OFFSET: next_hrdata = {29'h0, modeReg, 1'b0};
        STATUS_OFFSET: next_hrdata = statusWord;
        OPER_OFFSET: next_hrdata = {16'h0, operReg};
        ISSUE_OFFSET: next_hrdata = {14'h0, issueReg};
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      wrPending <= 1'b0;
      wrAddr <= 8'h00;
      modeReg <= CTRL_MODE_RESET;
      operReg <= OPER_RESET;
      issueReg <= '0;
      startPulse <= 1'b0;
      issuePulse <= 1'b0;
      doneFlag <= 1'b0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrPending <= next_wrPending;
      wrAddr <= next_wrAddr;
      modeReg <= next_modeReg;
      operReg <= next_operReg;
      issueReg <= next_issueReg;
      startPulse <= next_startPulse;
      issuePulse <= next_issuePulse;
      doneFlag <= next_doneFlag;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multiply sequence
  mul_sequencer #(
    .WIDTH(MUL_WIDTH)
  ) mul_sequencer_inst (
    .refClk(ref_clk),
    .rstSyncN(rstSyncN),
    .start(startPulse),
    .issue(issuePulse),
    .issueWord(issueReg),
    .operands(operReg),
    .state(seqState),
    .count(seqCount),
    .stepActive(seqStep),
    .done(seqDone),
    .dest(seqDest),
    .func(seqFunc),
    .src(seqSrc),
    .carry(seqCarry),
    .aAddr(seqA),
    .bAddr(seqB)
  );

  assign destinationField = seqDest;
  assign functionField = seqFunc;
  assign carryInput = seqCarry;
  assign aAddress = seqA;
  assign bAddress = seqB;
  // Multiplier bit steers A,B versus 0,B in the same cycle, so this path
  // cannot wait for a flip-flop
  assign sourceField = seqStep ?
                       {seqSrc[2], !qLowShiftIn, seqSrc[0]} : seqSrc;

  ////////////////////////////////////////////////////////////////////////////
  // End-of-array shift multiplexers
  logic [1:0] endMode;
  logic signFill;
  logic lowOe, highOe;

  // Multiply runs the double-length arithmetic shift with corrected sign
  assign endMode = seqStep ? MODE_ARITH : modeReg;
  assign signFill = aluSignOut ^ (seqStep && overflowFlag);

  shift_end_mux shift_end_mux_inst (
    .mode(endMode),
    .shifting(seqDest[2]),
    .up(seqDest[1]),
    .signIn(signFill),
    .fileLowIn(fileShiftLowIn),
    .fileHighIn(fileShiftHighIn),
    .qLowIn(qLowShiftIn),
    .qHighIn(qHighShiftIn),
    .fileLowOut(fileShiftLowOut),
    .fileHighOut(fileShiftHighOut),
    .qLowOut(qLowShiftOut),
    .qHighOut(qHighShiftOut),
    .lowOe(lowOe),
    .highOe(highOe)
  );

  // Enables follow registered lines, so no pin turns around mid-cycle
  assign fileShiftLowOe = lowOe;
  assign qLowShiftOe = lowOe;
  assign fileShiftHighOe = highOe;
  assign qHighShiftOe = highOe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks hold only once reset has been released
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstSyncN);

  one_end_a: assert property (!(fileShiftLowOe && fileShiftHighOe) &&
    (fileShiftHighOe == (destinationField[2] && !destinationField[1])))
    else $error("both array ends driven or wrong end");
  zero_down_a: assert property (fileShiftHighOe &&
    endMode == MODE_ZERO |-> !fileShiftHighOut && !qHighShiftOut)
    else $error("zero mode down shift not low");
  zero_up_a: assert property (fileShiftLowOe &&
    endMode == MODE_ZERO |-> !fileShiftLowOut && !qLowShiftOut)
    else $error("zero mode up shift not low");
  one_fill_a: assert property (endMode == MODE_ONE &&
    destinationField[2] |->
    (fileShiftLowOe ? fileShiftLowOut && qLowShiftOut
                    : fileShiftHighOut && qHighShiftOut))
    else $error("one mode fill not high");
  rotate_wrap_a: assert property (endMode == MODE_ROTATE && highOe |->
    fileShiftHighOut == fileShiftLowIn && qHighShiftOut == qLowShiftIn)
    else $error("rotate wrap wrong");
  arith_up_a: assert property (endMode == MODE_ARITH && lowOe |->
    !qLowShiftOut && fileShiftLowOut == qHighShiftIn)
    else $error("arithmetic up shift wrong");
  mul_link_a: assert property (seqStep |-> qHighShiftOe &&
    qHighShiftOut == fileShiftLowIn &&
    fileShiftHighOut == (aluSignOut ^ overflowFlag))
    else $error("multiply shift links wrong");
  cond_add_a: assert property (seqStep |->
    sourceField == (qLowShiftIn ? SRC_AB : SRC_ZB))
    else $error("conditional operand select wrong");
  done_sticky_a: assert property (seqDone |=> doneFlag)
    else $error("done flag not set");
  rotate_up_a: assert property (endMode == MODE_ROTATE && lowOe |->
    fileShiftLowOut == fileShiftHighIn && qLowShiftOut == qHighShiftIn)
    else $error("rotate up wrap wrong");
  arith_down_a: assert property (endMode == MODE_ARITH && highOe |->
    qHighShiftOut == fileShiftLowIn && fileShiftHighOut == signFill)
    else $error("arithmetic down shift wrong");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  start_busy_a: assert property (startPulse && seqState != ST_IDLE |=>
    seqState != ST_LOADQ)
    else $error("start accepted while busy");
  step_lines_a: assert property (seqStep |->
    destinationField == DEST_SHIFT_DOWN && functionField ==
    ((seqState == ST_SUB) ? FUNC_SUB : FUNC_ADD))
    else $error("multiply step lines wrong");

  manual_rotate_c: cover property (modeReg == MODE_ROTATE && lowOe);
  overflow_step_c: cover property (seqStep && overflowFlag);
  arith_shift_c: cover property (modeReg == MODE_ARITH && highOe && !seqStep);

endmodule
